// *** src/fis_pkg.sv ***
// Package for the force indicator status register bank
package fis_pkg;
   // Status word bit positions, first word
   localparam int unsigned S1_REL_OVF = 0;
   localparam int unsigned S1_ABS_OVF = 1;
   localparam int unsigned S1_FLOW_OVF = 2;
   localparam int unsigned S1_ZERO_DISP = 3;
   localparam int unsigned S1_ZERO_ABS = 4;
   localparam int unsigned S1_ZERO_REL = 5;
   localparam int unsigned S1_MOTION = 7;
   localparam int unsigned S1_SHUNT = 8;
   localparam int unsigned S1_REL_PREC = 12;
   localparam int unsigned S1_ABS_PREC = 13;
   localparam int unsigned S1_CAL_EDIT = 15;
   // Status word bit positions, second word
   localparam int unsigned S2_RELAY1 = 0;
   localparam int unsigned S2_RELAY2 = 1;
   localparam int unsigned S2_BUS_ERR = 2;
   localparam int unsigned S2_OUT_MODE = 3;
   localparam int unsigned S2_PWR_FAIL = 4;
   localparam int unsigned S2_DIN1 = 7;
   localparam int unsigned S2_DIN2 = 8;
   localparam int unsigned S2_LEVEL1 = 9;
   localparam int unsigned S2_LEVEL2 = 10;
   localparam int unsigned S2_AOUT1_MODE = 11;
   localparam int unsigned S2_SP1_ACT = 12;
   localparam int unsigned S2_SP2_ACT = 13;
   localparam int unsigned S2_SP1_DONE = 14;
   localparam int unsigned S2_SP2_DONE = 15;
   // Register indices on the read port
   localparam logic [2:0] IDX_STATUS1 = 3'h0;
   localparam logic [2:0] IDX_STATUS2 = 3'h1;
   localparam logic [2:0] IDX_ABS_FORCE = 3'h2;
   localparam logic [2:0] IDX_REL_FORCE = 3'h3;
   localparam logic [2:0] IDX_ERR_CODE = 3'h4;
   // Reset values and limits
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam logic [6:0] ERR_CODE_MAX = 7'h63;
   localparam logic [6:0] ERR_NONE = 7'h00;
   // Raw conditions of the measurement side
   typedef struct packed {
      logic rel_ovf;
      logic abs_ovf;
      logic flow_ovf;
      logic zero_disp;
      logic zero_abs;
      logic zero_rel;
      logic motion;
      logic shunt_on;
      logic rel_prec;
      logic abs_prec;
      logic cal_edit;
   } fis_meas_t;
   // Raw conditions of the I/O side
   typedef struct packed {
      logic relay1;
      logic relay2;
      logic bus_err;
      logic out_volt;
      logic din1;
      logic din2;
      logic level1;
      logic level2;
      logic aout1_volt;
      logic sp1_act;
      logic sp2_act;
      logic sp1_done;
      logic sp2_done;
   } fis_io_t;
   // Register read request from the link side
   typedef struct packed {
      logic valid;
      logic holding;
      logic [2:0] index;
   } fis_rd_req_t;
endpackage

// *** src/fis_status_regs.sv ***
// Status and force register bank of the force indicator
// Contract
// - First word bit 0 set when relative force integer does not fit.
// - First word bit 1 set when absolute force integer overflows.
// - First word bit 2 set when flow rate integer overflows.
// - Bits 3,4,5 flag good zero of displayed, absolute, relative force.
// - First word bit 8 is one while shunt resistor is connected.
// - Bits 12 and 13 flag relative and absolute force beyond six digits.
// - Second word bits 0 and 1 follow relays 1 and 2.
// - Second word bit 2 is set while an I/O bus error exists.
// - Second word bit 3 shows output mode, one meaning voltage.
// - Power failure bit reads set once, then a function 03 read clears it.
// - Second word bits 7 and 8 follow digital inputs 1 and 2.
// - Second word bits 9 and 10 show force above levels 1 and 2.
// - Second word bit 11 shows analogue output 1 mode.
// - Bits 12,13 setpoints active; bits 14,15 setpoint cycles done.
// - With shunt connected, force registers carry the shunt test value.
// - Error code register holds zero or a fault code up to 99.
module fis_status_regs (
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   input wire fis_pkg::fis_meas_t i_meas,
   input wire fis_pkg::fis_io_t i_io,
   input wire logic i_pwr_fail,
   input wire logic [15:0] i_abs_force,
   input wire logic [15:0] i_rel_force,
   input wire logic [15:0] i_shunt_value,
   input wire logic [6:0] i_err_code,
   input wire fis_pkg::fis_rd_req_t i_rd,
   output logic o_rd_valid,
   output logic [15:0] o_rd_data,
   output logic o_rd_error
);

   logic [15:0] status1;
   logic [15:0] status2;
   logic pwr_fail;
   logic [6:0] err_code;
   logic [15:0] abs_force;
   logic [15:0] rel_force;
   logic clear_pf;
   logic [15:0] next_rd_data;
   logic next_rd_error;

   // Index match, shared by read decode and power flag clear
   function automatic logic idx_is(input logic [2:0] idx, input logic [2:0] want);
      return idx == want;
   endfunction

   // First status word, rebuilt every cycle from live conditions
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_b)
      begin
         status1 <= fis_pkg::WORD_RESET;
      end
      else
      begin
         status1 <= fis_pkg::WORD_RESET;
         status1[fis_pkg::S1_REL_OVF] <= i_meas.rel_ovf;
         status1[fis_pkg::S1_ABS_OVF] <= i_meas.abs_ovf;
         status1[fis_pkg::S1_FLOW_OVF] <= i_meas.flow_ovf;
         status1[fis_pkg::S1_ZERO_DISP] <= i_meas.zero_disp;
         status1[fis_pkg::S1_ZERO_ABS] <= i_meas.zero_abs;
         status1[fis_pkg::S1_ZERO_REL] <= i_meas.zero_rel;
         status1[fis_pkg::S1_MOTION] <= i_meas.motion;
         status1[fis_pkg::S1_SHUNT] <= i_meas.shunt_on;
         status1[fis_pkg::S1_REL_PREC] <= i_meas.rel_prec;
         status1[fis_pkg::S1_ABS_PREC] <= i_meas.abs_prec;
         status1[fis_pkg::S1_CAL_EDIT] <= i_meas.cal_edit;
      end
   end

   // Second status word, power failure bit merged at read time
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_b)
      begin
         status2 <= fis_pkg::WORD_RESET;
      end
      else
      begin
         status2 <= fis_pkg::WORD_RESET;
         status2[fis_pkg::S2_RELAY1] <= i_io.relay1;
         status2[fis_pkg::S2_RELAY2] <= i_io.relay2;
         status2[fis_pkg::S2_BUS_ERR] <= i_io.bus_err;
         status2[fis_pkg::S2_OUT_MODE] <= i_io.out_volt;
         status2[fis_pkg::S2_DIN1] <= i_io.din1;
         status2[fis_pkg::S2_DIN2] <= i_io.din2;
         status2[fis_pkg::S2_LEVEL1] <= i_io.level1;
         status2[fis_pkg::S2_LEVEL2] <= i_io.level2;
         status2[fis_pkg::S2_AOUT1_MODE] <= i_io.aout1_volt;
         status2[fis_pkg::S2_SP1_ACT] <= i_io.sp1_act;
         status2[fis_pkg::S2_SP2_ACT] <= i_io.sp2_act;
         status2[fis_pkg::S2_SP1_DONE] <= i_io.sp1_done;
         status2[fis_pkg::S2_SP2_DONE] <= i_io.sp2_done;
      end
   end

   // Only a holding-register read of the second word clears the flag
   assign clear_pf = i_rd.valid && i_rd.holding && idx_is(i_rd.index, fis_pkg::IDX_STATUS2);

   // Sticky power failure; a new failure in the clearing cycle wins
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_b)
      begin
         pwr_fail <= 1'b0;
      end
      else if (i_pwr_fail)
      begin
         pwr_fail <= 1'b1;
      end
      else if (clear_pf)
      begin
         pwr_fail <= 1'b0;
      end
   end

   // Force values, swapped for the shunt test value while shunt is on
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_b)
      begin
         abs_force <= fis_pkg::WORD_RESET;
         rel_force <= fis_pkg::WORD_RESET;
      end
      else if (i_meas.shunt_on)
      begin
         abs_force <= i_shunt_value;
         rel_force <= i_shunt_value;
      end
      else
      begin
         abs_force <= i_abs_force;
         rel_force <= i_rel_force;
      end
   end

   // Error code; out-of-range codes are saturated to keep the range
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_b)
      begin
         err_code <= fis_pkg::ERR_NONE;
      end
      else if (i_err_code > fis_pkg::ERR_CODE_MAX)
      begin
         err_code <= fis_pkg::ERR_CODE_MAX;
      end
      else
      begin
         err_code <= i_err_code;
      end
   end

   // Read decode; the reply carries the power flag before it clears
   always_comb
   begin
      next_rd_data = fis_pkg::WORD_RESET;
      next_rd_error = 1'b0;
      if (idx_is(i_rd.index, fis_pkg::IDX_STATUS1))
      begin
         next_rd_data = status1;
      end
      else if (idx_is(i_rd.index, fis_pkg::IDX_STATUS2))
      begin
         next_rd_data = status2;
         next_rd_data[fis_pkg::S2_PWR_FAIL] = pwr_fail;
      end
      else if (idx_is(i_rd.index, fis_pkg::IDX_ABS_FORCE))
      begin
         next_rd_data = abs_force;
      end
      else if (idx_is(i_rd.index, fis_pkg::IDX_REL_FORCE))
      begin
         next_rd_data = rel_force;
      end
      else if (idx_is(i_rd.index, fis_pkg::IDX_ERR_CODE))
      begin
         next_rd_data = {9'h000, err_code};
      end
      else
      begin
         next_rd_error = 1'b1;
      end
   end

   // Registered reply, one cycle after the request
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_b)
      begin
         o_rd_valid <= 1'b0;
         o_rd_data <= fis_pkg::WORD_RESET;
         o_rd_error <= 1'b0;
      end
      else
      begin
         o_rd_valid <= i_rd.valid;
         o_rd_error <= i_rd.valid && next_rd_error;
         if (i_rd.valid)
         begin
            o_rd_data <= next_rd_data;
         end
      end
   end

   // Power flag reported then cleared by a holding read
   pwr_fail_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      pwr_fail && clear_pf && !i_pwr_fail |=> o_rd_data[fis_pkg::S2_PWR_FAIL] && !pwr_fail)
      else $error("power flag not reported or not cleared");

   // New failure beats the clear
   pwr_fail_set_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      i_pwr_fail |=> pwr_fail)
      else $error("power failure not latched");

   // Relay 1 bit follows two cycles on at read
   relay_bit_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      ##1 i_rd.valid && idx_is(i_rd.index, fis_pkg::IDX_STATUS2)
      |=> o_rd_data[fis_pkg::S2_RELAY1] == $past(i_io.relay1, 2))
      else $error("relay bit mismatch");

   // Overflow flag of absolute force
   abs_ovf_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      i_meas.abs_ovf |=> status1[fis_pkg::S1_ABS_OVF])
      else $error("absolute overflow flag missing");

   // Shunt value substituted
   shunt_value_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      i_meas.shunt_on |=> abs_force == $past(i_shunt_value) && rel_force == $past(i_shunt_value))
      else $error("shunt value not placed");

   // Reserved bits stay zero
   reserved_zero_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      status2[6:5] == 2'h0 && status1[11:9] == 3'h0 && status1[6] == 1'b0 && status1[14] == 1'b0)
      else $error("reserved bit set");

   // Error code stays in range
   err_range_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      err_code <= fis_pkg::ERR_CODE_MAX)
      else $error("error code out of range");

   // Shunt flag follows the condition and drops by itself
   shunt_flag_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      !i_meas.shunt_on |=> !status1[fis_pkg::S1_SHUNT])
      else $error("shunt flag stuck");

   // Level 2 bit tracks
   level_bit_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      i_io.level2 |=> status2[fis_pkg::S2_LEVEL2])
      else $error("level 2 flag missing");
endmodule

// *** dv/fis_master_model.sv ***
// Master computer model issuing register reads over the read port
module fis_master_model (
   input wire logic i_core_clk,
   input wire logic i_rd_valid,
   input wire logic [15:0] i_rd_data,
   input wire logic i_rd_error,
   output fis_pkg::fis_rd_req_t o_rd
);
   timeunit 1ns;
   timeprecision 100ps;

   // Idle port from time zero
   initial o_rd = '0;

   // One request pulse, then a bounded wait for the reply strobe
   task automatic rd(input logic [2:0] idx, input logic hold, output logic [15:0] d,
      output logic e, output bit ok);
      ok = 0;
      @(posedge i_core_clk);
      o_rd <= '{valid: 1'b1, holding: hold, index: idx};
      @(posedge i_core_clk);
      o_rd <= '0;
      for (int n = 0; n < 4 && !ok; n++)
      begin
         #1;
         if (i_rd_valid === 1'b1)
         begin
            ok = 1;
            d = i_rd_data;
            e = i_rd_error;
         end
         else
            @(posedge i_core_clk);
      end
   endtask

   // Force read after both status words; trusted only with a zero error code
   task automatic rd_force(input logic rel, output logic [15:0] f, output bit trusted,
      output bit ok);
      logic [15:0] s;
      logic [15:0] ec;
      logic e;
      bit k;
      rd(fis_pkg::IDX_STATUS1, 1'b0, s, e, ok);
      rd(fis_pkg::IDX_STATUS2, 1'b0, s, e, k);
      ok &= k;
      rd(rel ? fis_pkg::IDX_REL_FORCE : fis_pkg::IDX_ABS_FORCE, 1'b0, f, e, k);
      ok &= k;
      rd(fis_pkg::IDX_ERR_CODE, 1'b0, ec, e, k);
      ok &= k;
      trusted = (ec === 16'h0000);
   endtask
endmodule

// *** dv/force_indicator_status_regs_tb.sv ***
// Self-checking bench for the status register bank
module force_indicator_status_regs_tb;
   timeunit 1ns;
   timeprecision 100ps;

   logic i_core_clk = 1'b0;
   logic i_rst_b;
   fis_pkg::fis_meas_t i_meas;
   fis_pkg::fis_io_t i_io;
   logic i_pwr_fail;
   logic [15:0] i_abs_force;
   logic [15:0] i_rel_force;
   logic [15:0] i_shunt_value;
   logic [6:0] i_err_code;
   fis_pkg::fis_rd_req_t rd_req;
   logic rd_valid;
   logic [15:0] rd_data;
   logic rd_error;
   int err_count;
   int comparisons;
   int p1[11] = '{0, 1, 2, 3, 4, 5, 7, 8, 12, 13, 15};
   int p2[13] = '{0, 1, 2, 3, 7, 8, 9, 10, 11, 12, 13, 14, 15};
   logic [15:0] f;
   bit tr;
   bit ok;

   // 100 MHz clock
   always #5 i_core_clk = ~i_core_clk;

   fis_status_regs i_fis_status_regs (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
      .i_meas(i_meas), .i_io(i_io), .i_pwr_fail(i_pwr_fail), .i_abs_force(i_abs_force),
      .i_rel_force(i_rel_force), .i_shunt_value(i_shunt_value), .i_err_code(i_err_code),
      .i_rd(rd_req), .o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_rd_error(rd_error));

   fis_master_model i_fis_master_model (.i_core_clk(i_core_clk), .i_rd_valid(rd_valid),
      .i_rd_data(rd_data), .i_rd_error(rd_error), .o_rd(rd_req));

   // Counts, verdict and end of run
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Read one word; a missing reply ends the run
   task automatic chkrd(input logic [2:0] idx, input logic hold, input string nm,
      input logic [15:0] exp);
      logic [15:0] d;
      logic e;
      bit k;
      i_fis_master_model.rd(idx, hold, d, e, k);
      if (!k)
      begin
         chk({nm, " strobe"}, 16'h0001, 16'h0000);
         stop_test();
      end
      chk(nm, exp, d);
      chk({nm, " error"}, {15'h0, idx > 3'h4}, {15'h0, e});
   endtask

   // Main sequence
   initial
   begin
      {i_rst_b, i_pwr_fail, i_meas, i_io, i_err_code} = '0;
      {i_abs_force, i_rel_force, i_shunt_value} = '0;
      err_count = 0;
      comparisons = 0;
      repeat (20) @(posedge i_core_clk);
      i_rst_b <= 1'b1;
      chkrd(fis_pkg::IDX_STATUS1, 1'b0, "status1 idle", 16'h0000);
      chkrd(fis_pkg::IDX_STATUS2, 1'b1, "status2 idle", 16'h0000);
      $display("test reset done");
      // Walking one over every condition; the previous bit must drop
      for (int i = 0; i < 11; i++)
      begin
         @(posedge i_core_clk);
         i_meas <= 11'h1 << (10 - i);
         chkrd(3'h0, 1'b0, "status1 bit", 16'h1 << p1[i]);
      end
      @(posedge i_core_clk);
      i_meas <= '1;
      chkrd(3'h0, 1'b0, "status1 all", 16'hb1bf);
      for (int i = 0; i < 13; i++)
      begin
         @(posedge i_core_clk);
         i_io <= 13'h1 << (12 - i);
         chkrd(3'h1, 1'b1, "status2 bit", 16'h1 << p2[i]);
      end
      @(posedge i_core_clk);
      i_io <= '1;
      chkrd(3'h1, 1'b1, "status2 all", 16'hff8f);
      $display("test status bits done");
      // Sticky power flag survives a plain read, reports once on a holding read
      @(posedge i_core_clk);
      i_io <= '0;
      i_pwr_fail <= 1'b1;
      @(posedge i_core_clk);
      i_pwr_fail <= 1'b0;
      chkrd(3'h1, 1'b0, "power plain", 16'h0010);
      chkrd(3'h1, 1'b1, "power holding", 16'h0010);
      chkrd(3'h1, 1'b1, "power cleared", 16'h0000);
      $display("test power flag done");
      @(posedge i_core_clk);
      i_meas <= '0;
      i_abs_force <= 16'h1234;
      i_rel_force <= 16'hfedc;
      i_shunt_value <= 16'h5a5a;
      i_err_code <= 7'h05;
      chkrd(fis_pkg::IDX_ABS_FORCE, 1'b0, "abs force", 16'h1234);
      chkrd(fis_pkg::IDX_REL_FORCE, 1'b0, "rel force", 16'hfedc);
      chkrd(fis_pkg::IDX_ERR_CODE, 1'b0, "err code", 16'h0005);
      @(posedge i_core_clk);
      i_err_code <= 7'h78;
      i_meas <= '{shunt_on: 1'b1, default: 1'b0};
      chkrd(fis_pkg::IDX_ERR_CODE, 1'b0, "err code high", 16'h0063);
      chkrd(fis_pkg::IDX_ABS_FORCE, 1'b0, "abs shunt", 16'h5a5a);
      chkrd(fis_pkg::IDX_REL_FORCE, 1'b0, "rel shunt", 16'h5a5a);
      for (int i = 5; i < 8; i++)
         chkrd(3'(i), 1'b0, "unmapped", 16'h0000);
      $display("test force and error done");
      // Block reads from the master side
      @(posedge i_core_clk);
      i_meas <= '0;
      i_err_code <= 7'h00;
      i_fis_master_model.rd_force(1'b0, f, tr, ok);
      chk("abs block", 16'h1234, f);
      chk("abs trusted", 16'h0001, {15'h0, tr & ok});
      i_fis_master_model.rd_force(1'b1, f, tr, ok);
      chk("rel block", 16'hfedc, f);
      @(posedge i_core_clk);
      i_err_code <= 7'h05;
      i_fis_master_model.rd_force(1'b1, f, tr, ok);
      chk("rel distrusted", 16'h0000, {15'h0, tr | !ok});
      $display("test block read done");
      // Mid-run reset drops the sticky flag and the held reply word
      @(posedge i_core_clk);
      i_io <= '{relay1: 1'b1, default: 1'b0};
      i_pwr_fail <= 1'b1;
      @(posedge i_core_clk);
      i_pwr_fail <= 1'b0;
      i_rst_b <= 1'b0;
      repeat (3) @(posedge i_core_clk);
      i_rst_b <= 1'b1;
      #1;
      chk("reset data", 16'h0000, rd_data);
      chk("reset strobe", 16'h0000, {15'h0, rd_valid});
      chkrd(fis_pkg::IDX_STATUS2, 1'b1, "status2 after reset", 16'h0001);
      $display("test mid-run reset done");
      stop_test();
   end
endmodule
